// File: design/tld_pkg.sv
package tld_pkg;

  // register byte offsets
  localparam logic [9:0] TLD_OFF_CFG   = 10'h000;
  localparam logic [9:0] TLD_OFF_PULL  = 10'h004;
  localparam logic [9:0] TLD_OFF_STAT  = 10'h008;
  localparam logic [9:0] TLD_OFF_SPLIT = 10'h00c;
  localparam logic [9:0] TLD_OFF_DEC   = 10'h010;
  localparam logic [9:0] TLD_OFF_TBL   = 10'h040;
  localparam logic [9:0] TLD_TBL_BYTES = 10'h100;

  // reset values
  localparam logic [31:0] TLD_CFG_RST   = 32'h0000_0000;
  localparam logic [1:0]  TLD_PULL_RST  = 2'h0;
  localparam logic [15:0] TLD_SPLIT_RST = 16'h0000;

  // driver config field layout, one nibble per driver
  localparam int TLD_DRV_FIELD = 4;
  localparam int TLD_MODE_POS  = 0;
  localparam int TLD_WIDTH_POS = 2;

  // array geometry
  localparam int TLD_LINES     = 2;
  localparam int TLD_DRV_LINE  = 4;
  localparam int TLD_DRV_IN    = 16;
  localparam int TLD_EDGES     = 4;
  localparam int TLD_DEC_EDGE  = 4;
  localparam int TLD_DEC_WORDS = 4;
  localparam int TLD_DEC_MAX   = 64;
  localparam int TLD_ROW_VARS  = 3;

  // decoder input capacity across array sizes
  localparam int TLD_CAP_SMALL = 42;
  localparam int TLD_CAP_MID   = 72;
  localparam int TLD_CAP_LARGE = 96;
  localparam int TLD_CAP_MAX   = 132;

  // driver configurations; code 3 is illegal and releases the line
  typedef enum logic [1:0] {
    TLD_PLAIN,
    TLD_WAND,
    TLD_ORAND
  } tld_mode_t;

  // wired-and variants: 1, 4, 8 or 16 open-drain inputs
  function automatic logic [15:0] tld_width_mask(input logic [1:0] code);
    unique case (code)
      2'h0:    tld_width_mask = 16'h0001;
      2'h1:    tld_width_mask = 16'h000f;
      2'h2:    tld_width_mask = 16'h00ff;
      default: tld_width_mask = 16'hffff;
    endcase
  endfunction

  // one product term: every selected input matches its polarity
  function automatic logic tld_and_term(input logic [63:0] sel,
                                        input logic [63:0] inv,
                                        input logic [63:0] in);
    tld_and_term = &(~sel | (in ^ inv));
  endfunction

endpackage

// File: design/tld_drv.sv
`timescale 1ns/1ps
module tld_drv
  import tld_pkg::*;
#(
  parameter int IN_W = TLD_DRV_IN
) (
  // configuration
  input  wire logic [1:0]      mode,
  input  wire logic [1:0]      wcode,
  // data and control from the neighbouring cell
  input  wire logic [IN_W-1:0] dataIn,
  input  wire logic            orB,
  input  wire logic            tsCtl,
  // line drive
  output logic                 pullLow,
  output logic                 driveHigh
);

  logic [IN_W-1:0] effIn;

  // unused inputs of a narrow variant read as released
  always_comb begin
    effIn     = dataIn | ~IN_W'(tld_width_mask(wcode));
    pullLow   = 1'b0;
    driveHigh = 1'b0;
    unique case (mode)
      TLD_PLAIN: begin
        if (!tsCtl) begin
          pullLow   = ~dataIn[0];
          driveHigh = dataIn[0];
        end
      end
      TLD_WAND: pullLow = ~&effIn;
      TLD_ORAND: pullLow = ~dataIn[0] & ~orB;
      default: begin
        pullLow   = 1'b0;
        driveHigh = 1'b0;
      end
    endcase
  end

endmodule

// File: design/tld_edge_bus.sv
`timescale 1ns/1ps
// Function
// - three driver configurations per shared line
// - plain driver floats on tristate high
// - wired-and: low input drives low
// - open-drain line high only all high
// - or-and: low only both inputs low
// - wired-and in 1/4/8/16 input variants
// - four decoders on each array edge
// - decoder takes edge pads plus row signals
// - row gives three variables, either polarity
// - decoder high when product term true
// - decoder width scales 42 to 132; terms use only the first 64 inputs
// - decoders split in two, 32 total
// - decoder outputs reach cells or pins
// - two lines, above and below cell
// - keeper holds undriven line level while pull-up is off
module tld_edge_bus
  import tld_pkg::*;
#(
  parameter int DEC_WIDTH = TLD_CAP_SMALL
) (
  // clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  // register port
  input  wire logic [9:0]                     regAddr,
  input  wire logic [31:0]                    regWdata,
  input  wire logic                           regWr,
  input  wire logic                           regRd,
  output logic      [31:0]                    regRdata,
  // shared-line drivers from logic cells
  input  wire logic [TLD_LINES*TLD_DRV_LINE*TLD_DRV_IN-1:0] drvData,
  input  wire logic [TLD_LINES*TLD_DRV_LINE-1:0] drvOrB,
  input  wire logic [TLD_LINES*TLD_DRV_LINE-1:0] drvTs,
  // decoder inputs per edge: pad signals then row signals
  input  wire logic [TLD_EDGES*DEC_WIDTH-1:0] decIn,
  // resolved lines and decoder outputs
  output logic      [TLD_LINES-1:0]           lineOut,
  output logic      [TLD_LINES-1:0]           lineClash,
  output logic      [2*TLD_EDGES*TLD_DEC_EDGE-1:0] decOut
);

  localparam int NDRV  = TLD_LINES * TLD_DRV_LINE;
  localparam int NDEC  = TLD_EDGES * TLD_DEC_EDGE;
  localparam int NWORD = NDEC * TLD_DEC_WORDS;
  localparam int HALF  = DEC_WIDTH / 2;
  localparam logic [63:0] FULL_MASK = 64'((65'h1 << DEC_WIDTH) - 65'h1);
  localparam logic [63:0] LOW_MASK  = 64'((65'h1 << HALF) - 65'h1);

  typedef struct packed {
    logic [31:0]            cfg;
    logic [TLD_LINES-1:0]   pullEn;
    logic [NDEC-1:0]        split;
    logic [NWORD-1:0][31:0] tbl;
    logic [TLD_LINES-1:0]   line;
    logic [TLD_LINES-1:0]   clash;
    logic [2*NDEC-1:0]      dec;
    logic [31:0]            rdata;
  } tld_state_t;

  tld_state_t s_r;
  tld_state_t s_nxt;

  logic [NDRV-1:0] drvLow;
  logic [NDRV-1:0] drvHigh;
  logic            inTbl;
  logic [5:0]      tblIdx;
  logic [9:0]      tblOff;

  // per-driver logic, one configuration nibble each
  for (genvar j = 0; j < NDRV; j++) begin : g_drv
    tld_drv #(
      .IN_W (TLD_DRV_IN)
    ) u_drv (
      .mode      (s_r.cfg[j*TLD_DRV_FIELD+TLD_MODE_POS +: 2]),
      .wcode     (s_r.cfg[j*TLD_DRV_FIELD+TLD_WIDTH_POS +: 2]),
      .dataIn    (drvData[j*TLD_DRV_IN +: TLD_DRV_IN]),
      .orB       (drvOrB[j]),
      .tsCtl     (drvTs[j]),
      .pullLow   (drvLow[j]),
      .driveHigh (drvHigh[j])
    );
  end

  // decoder table window decode
  assign tblOff = regAddr - TLD_OFF_TBL;
  assign inTbl  = (regAddr >= TLD_OFF_TBL) &&
                  (regAddr < TLD_OFF_TBL + TLD_TBL_BYTES) &&
                  (regAddr[1:0] == 2'h0);
  assign tblIdx = tblOff[7:2];

  // next state: register port, line resolution, decoders
  always_comb begin
    logic              anyLow;
    logic              anyHigh;
    logic [63:0]       vec;
    logic [63:0]       sel;
    logic [63:0]       inv;
    logic              tFull;
    logic              tLow;
    logic              tHigh;
    s_nxt       = s_r;
    s_nxt.rdata = 32'h0;
    anyLow      = 1'b0;
    anyHigh     = 1'b0;
    vec         = 64'h0;
    sel         = 64'h0;
    inv         = 64'h0;
    tFull       = 1'b0;
    tLow        = 1'b0;
    tHigh       = 1'b0;

    // register writes; status words are read-only
    if (regWr) begin
      if (regAddr == TLD_OFF_CFG) begin
        s_nxt.cfg = regWdata;
      end else if (regAddr == TLD_OFF_PULL) begin
        s_nxt.pullEn = regWdata[TLD_LINES-1:0];
      end else if (regAddr == TLD_OFF_SPLIT) begin
        s_nxt.split = regWdata[NDEC-1:0];
      end else if (inTbl) begin
        s_nxt.tbl[tblIdx] = regWdata;
      end
    end

    // read data stands only in the cycle after the strobe
    if (regRd) begin
      if (regAddr == TLD_OFF_CFG) begin
        s_nxt.rdata = s_r.cfg;
      end else if (regAddr == TLD_OFF_PULL) begin
        s_nxt.rdata = 32'(s_r.pullEn);
      end else if (regAddr == TLD_OFF_STAT) begin
        s_nxt.rdata = 32'({s_r.clash, s_r.line});
      end else if (regAddr == TLD_OFF_SPLIT) begin
        s_nxt.rdata = 32'(s_r.split);
      end else if (regAddr == TLD_OFF_DEC) begin
        s_nxt.rdata = s_r.dec;
      end else if (inTbl) begin
        s_nxt.rdata = s_r.tbl[tblIdx];
      end
    end

    for (int l = 0; l < TLD_LINES; l++) begin
      anyLow  = 1'b0;
      anyHigh = 1'b0;
      for (int k = 0; k < TLD_DRV_LINE; k++) begin
        anyLow  = anyLow  | drvLow[l*TLD_DRV_LINE+k];
        anyHigh = anyHigh | drvHigh[l*TLD_DRV_LINE+k];
      end
      if (anyLow) begin
        s_nxt.line[l] = 1'b0;
      end else if (anyHigh || s_r.pullEn[l]) begin
        s_nxt.line[l] = 1'b1;
      end else begin
        s_nxt.line[l] = s_r.line[l];
      end
      s_nxt.clash[l] = anyLow & anyHigh;
    end

    // wide decoders, four per edge
    // four per edge, sixteen total
    for (int d = 0; d < NDEC; d++) begin
      vec = 64'(decIn[(d/TLD_DEC_EDGE)*DEC_WIDTH +: DEC_WIDTH]);
      sel = {s_r.tbl[d*TLD_DEC_WORDS+1], s_r.tbl[d*TLD_DEC_WORDS]}
            & FULL_MASK;
      inv = {s_r.tbl[d*TLD_DEC_WORDS+3], s_r.tbl[d*TLD_DEC_WORDS+2]};
      tFull = tld_and_term(sel, inv, vec);
      tLow  = tld_and_term(sel & LOW_MASK, inv, vec);
      tHigh = tld_and_term(sel & ~LOW_MASK, inv, vec);
      s_nxt.dec[2*d]   = s_r.split[d] ? tLow : tFull;
      s_nxt.dec[2*d+1] = s_r.split[d] ? tHigh : 1'b0;
    end
  end

  // state register; configuration has documented reset values
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r        <= '0;
      s_r.cfg    <= TLD_CFG_RST;
      s_r.pullEn <= TLD_PULL_RST;
      s_r.split  <= TLD_SPLIT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign regRdata  = s_r.rdata;
  assign lineOut   = s_r.line;
  assign lineClash = s_r.clash;
  assign decOut    = s_r.dec;

  // helper terms for the checks below, line 0 only
  logic allPlainOff0;
  logic onlyDrv0On0;
  logic wandLow0;
  logic orandLow0;
  assign allPlainOff0 = (s_r.cfg[15:0] == 16'h0) && (drvTs[3:0] == 4'hf);
  assign onlyDrv0On0  = (s_r.cfg[15:0] == 16'h0) && (drvTs[3:0] == 4'he);
  assign wandLow0     = (s_r.cfg[3:0] == 4'h1) && !drvData[0];
  assign orandLow0    = (s_r.cfg[1:0] == 2'h2) && !drvData[0] && !drvOrB[0];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_plain_follow: assert property (
    onlyDrv0On0 |=> lineOut[0] == $past(drvData[0]))
    else $error("plain driver not followed");

  a_keeper_holds: assert property (
    allPlainOff0 && !s_r.pullEn[0] |=> $stable(lineOut[0]))
    else $error("undriven line changed");

  a_pullup_high: assert property (
    allPlainOff0 && s_r.pullEn[0] |=> lineOut[0])
    else $error("pulled-up line not high");

  a_wand_low: assert property (
    wandLow0 |=> !lineOut[0] &&
      lineClash[0] == ($past(drvHigh[3:1]) != 3'h0))
    else $error("wired-and low not seen");

  a_orand_low: assert property (
    orandLow0 |=> !lineOut[0])
    else $error("or-and low not seen");

  a_clash_flag: assert property (
    (|drvLow[3:0]) && (|drvHigh[3:0]) |=> lineClash[0] && !lineOut[0])
    else $error("contention not flagged");

  a_dec_empty: assert property (
    s_r.tbl[1:0] == 64'h0 && !s_r.split[0] |=> decOut[1:0] == 2'h1)
    else $error("empty product term not high");

  a_dec_unsplit: assert property (
    !s_r.split[5] |=> !decOut[11])
    else $error("unsplit upper output active");

  a_read_latency: assert property (
    regRd && regAddr == TLD_OFF_SPLIT && !regWr
      |=> regRdata == 32'($past(s_r.split)) ##1 regRdata == 32'h0 || $past(regRd))
    else $error("read data timing wrong");

  // driver-level checks, same cycle as the inputs
  a_released_off: assert property (
    s_r.cfg[21:20] == 2'h3 |-> !drvLow[5] && !drvHigh[5])
    else $error("released driver still drives");

  a_plain_float: assert property (
    s_r.cfg[1:0] == 2'h0 && drvTs[0] |-> !drvLow[0] && !drvHigh[0])
    else $error("floating plain driver drives");

  a_wand_release: assert property (
    s_r.cfg[3:0] == 4'h1 && drvData[0] |-> !drvLow[0] && !drvHigh[0])
    else $error("wired-and high input drives");

  a_wand_width: assert property (
    s_r.cfg[11:8] == 4'h5 && !drvData[35] |-> drvLow[2])
    else $error("four-input wired-and missed low");

  a_wand_unused: assert property (
    s_r.cfg[11:8] == 4'h5 && drvData[47:32] == 16'hffef |-> !drvLow[2])
    else $error("unused wired-and input pulled");

  a_orand_release: assert property (
    s_r.cfg[17:16] == 2'h2 && (drvData[64] || drvOrB[4]) |-> !drvLow[4])
    else $error("or-and high input pulled low");

  // line-level and idle read-data checks, one cycle after their inputs
  a_line_high: assert property (
    !(|drvLow[3:0]) && s_r.pullEn[0] |=> lineOut[0])
    else $error("released wired-and line not high");

  a_line1_low: assert property (
    (|drvLow[7:4]) |=> !lineOut[1])
    else $error("second line not pulled low");

  a_pullup_line1: assert property (
    !(|drvLow[7:4]) && s_r.pullEn[1] |=> lineOut[1])
    else $error("second line pull-up not high");

  a_clash_clear: assert property (
    !(|drvHigh[3:0]) |=> !lineClash[0])
    else $error("contention flag without driver");

  a_read_idle: assert property (
    !regRd |=> regRdata == 32'h0)
    else $error("read data outside read cycle");

endmodule

// File: sim/tld_cell_model.sv
`timescale 1ns/1ps
// neighbouring cells: choose which drivers reach the lines
module tld_cell_model
  import tld_pkg::*;
(
  // selection from the controlling logic
  input  wire logic [2:0]   muxSel,
  input  wire logic         muxEn,
  input  wire logic         clashEn,
  input  wire logic [127:0] cellData,
  input  wire logic [7:0]   cellOrB,
  // driver side
  output logic      [127:0] drvData,
  output logic      [7:0]   drvOrB,
  output logic      [7:0]   drvTs
);
  // select by tristate
  // a second enable only when a clash is asked for on purpose
  always_comb begin
    drvTs = 8'hff;
    if (muxEn) begin
      drvTs[muxSel] = 1'b0;
    end
    if (clashEn) begin
      drvTs[muxSel ^ 3'h1] = 1'b0;
    end
  end
  assign drvData = cellData;
  assign drvOrB  = cellOrB;
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import tld_pkg::*;
;
  // bench signals
  logic         clk_sys;
  logic         rst_n;
  logic [9:0]   regAddr;
  logic [31:0]  regWdata;
  logic         regWr;
  logic         regRd;
  logic [31:0]  regRdata;
  logic [2:0]   muxSel;
  logic         muxEn;
  logic         clashEn;
  logic [127:0] cellData;
  logic [7:0]   cellOrB;
  logic [127:0] drvData;
  logic [7:0]   drvOrB;
  logic [7:0]   drvTs;
  logic [167:0] decIn;
  logic [1:0]   lineOut;
  logic [1:0]   lineClash;
  logic [31:0]  decOut;
  logic [31:0]  rd;
  int           errCount;
  int           nChecks;

  // far side and block under test
  tld_cell_model tld_cell_model_inst (
    .muxSel(muxSel), .muxEn(muxEn), .clashEn(clashEn),
    .cellData(cellData), .cellOrB(cellOrB),
    .drvData(drvData), .drvOrB(drvOrB), .drvTs(drvTs));
  tld_edge_bus #(.DEC_WIDTH(42)) tld_edge_bus_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .drvData(drvData), .drvOrB(drvOrB),
    .drvTs(drvTs), .decIn(decIn), .lineOut(lineOut),
    .lineClash(lineClash), .decOut(decOut));

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  // result comparisons
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkPin(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // only the line or decoder result is registered, once: allow slack
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic regWrite(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // reset values and an unmapped read
  task automatic tReset();
    regRead(TLD_OFF_CFG, rd);
    chkReg(rd, TLD_CFG_RST);
    regRead(TLD_OFF_SPLIT, rd);
    chkReg(rd, 32'h0);
    regRead(10'h3fc, rd);
    chkReg(rd, 32'h0);
  endtask
  // plain drivers, keeper, second line
  task automatic tPlain();
    @(posedge clk_sys);
    muxEn    <= 1'b1;
    cellData <= 128'h1;
    settle();
    chkPin({30'h0, lineOut}, 32'h1);
    @(posedge clk_sys);
    cellData <= 128'h0;
    settle();
    chkPin({30'h0, lineOut}, 32'h0);
    @(posedge clk_sys);
    muxEn    <= 1'b0;
    cellData <= 128'h1;
    settle();
    chkPin({30'h0, lineOut}, 32'h0);
    @(posedge clk_sys);
    muxEn    <= 1'b1;
    muxSel   <= 3'h4;
    cellData <= {64'h1, 64'h0};
    settle();
    chkPin({30'h0, lineOut}, 32'h2);
  endtask
  // wired-and at every width: top used bit counts, next one not below width 16
  task automatic tWand();
    logic [3:0] nib;
    int         w;
    regWrite(TLD_OFF_PULL, 32'h1);
    for (int c = 0; c < 4; c++) begin
      nib = {c[1:0], 2'b01};
      w = (c == 0) ? 1 : (2 << c);
      regWrite(TLD_OFF_CFG, {16'h0, {4{nib}}});
      @(posedge clk_sys);
      cellData <= {64'h0, ~(64'h1 << (32 + w - 1))};
      settle();
      chkPin({31'h0, lineOut[0]}, 32'h0);
      @(posedge clk_sys);
      cellData <= {64'h0, ~(64'h1 << (32 + w))};
      settle();
      chkPin({31'h0, lineOut[0]}, {31'h0, w < 16});
    end
  endtask
  // or-and on line 1
  task automatic tOrAnd();
    regWrite(TLD_OFF_CFG, 32'h2222_0000);
    regWrite(TLD_OFF_PULL, 32'h2);
    @(posedge clk_sys);
    cellData <= 128'h0;
    cellOrB  <= 8'hdf;
    settle();
    chkPin({31'h0, lineOut[1]}, 32'h0);
    @(posedge clk_sys);
    cellData <= {32'h0, 16'h1, 80'h0};
    settle();
    chkPin({31'h0, lineOut[1]}, 32'h1);
    // driver 5 switched off: its low inputs must not pull the line
    regWrite(TLD_OFF_CFG, 32'h2232_0000);
    @(posedge clk_sys);
    cellData <= 128'h0;
    settle();
    chkPin({31'h0, lineOut[1]}, 32'h1);
  endtask
  // two plain drivers fighting: low wins, flag raised
  task automatic tClash();
    regWrite(TLD_OFF_CFG, 32'h0);
    @(posedge clk_sys);
    muxSel   <= 3'h0;
    clashEn  <= 1'b1;
    cellData <= 128'h1;
    settle();
    chkPin({30'h0, lineClash}, 32'h1);
    chkPin({31'h0, lineOut[0]}, 32'h0);
    regRead(TLD_OFF_STAT, rd);
    chkReg(rd & 32'h4, 32'h4);
    @(posedge clk_sys);
    clashEn <= 1'b0;
  endtask
  // product terms on edges 0 and 1, then a split
  task automatic tDec();
    regWrite(TLD_OFF_TBL, 32'h3);
    regWrite(TLD_OFF_TBL + 10'h8, 32'h2);
    regWrite(TLD_OFF_TBL + 10'h44, 32'h200);
    @(posedge clk_sys);
    decIn <= 168'h1;
    settle();
    chkPin(decOut, 32'h5555_5455);
    @(posedge clk_sys);
    decIn <= (168'h1 << 83) | 168'h3;
    settle();
    chkPin(decOut, 32'h5555_5554);
    regWrite(TLD_OFF_SPLIT, 32'h1);
    @(posedge clk_sys);
    decIn <= 168'h1;
    settle();
    regRead(TLD_OFF_DEC, rd);
    chkReg(rd, 32'h5555_5457);
  endtask
  // reset in mid-run clears outputs and configuration
  task automatic tMidReset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    #1;
    chkPin(decOut, 32'h0);
    chkPin({28'h0, lineClash, lineOut}, 32'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    settle();
    regRead(TLD_OFF_PULL, rd);
    chkReg(rd, 32'h0);
    chkPin(decOut, 32'h5555_5555);
  endtask

  // main sequence
  initial begin
    clk_sys  = 1'b0;
    rst_n    = 1'b0;
    regAddr  = 10'h0;
    regWdata = 32'h0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    muxSel   = 3'h0;
    muxEn    = 1'b0;
    clashEn  = 1'b0;
    cellData = 128'h0;
    cellOrB  = 8'h0;
    decIn    = 168'h0;
    errCount = 0;
    nChecks  = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    tReset();
    tPlain();
    tWand();
    tOrAnd();
    tClash();
    tDec();
    tMidReset();
    wrap_up();
  end

  // watchdog, far beyond the roughly 130 cycles the tests need
  initial begin
    #100000;
    errCount++;
    wrap_up();
  end
endmodule
